// ==== dv/bsid_host_model.sv ====
`include "bsid_params.svh"
module bsid_host_model import bsid_pkg::*; (
  input wire logic clk_in,
  input wire logic dev_oe_in,
  input wire logic dev_out_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bus lines
  // ----------------------------------------
  logic scl_q = 1'b1; // host clock drive
  logic sda_q = 1'b1; // host data drive, 1 = released
  assign scl_out = scl_q;
  // pull-up, either side may pull low
  assign sda_out = sda_q & (dev_oe_in ? dev_out_in : 1'h1);
  // ----------------------------------------
  // bus phases
  // ----------------------------------------
  // one bus phase of 12 clocks (bit is three phases, clock high for one), change just after an edge
  task automatic hp();
    repeat (12) @(posedge clk_in);
    #2;
  endtask : hp
  // start or repeated start
  task automatic start();
    sda_q = 1'b1;
    hp();
    scl_q = 1'b1;
    hp();
    sda_q = 1'b0;
    hp();
    scl_q = 1'b0;
    hp();
  endtask : start
  // one bit out, line sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    sda_q = b;
    hp();
    scl_q = 1'b1;
    hp();
    r = sda_out;
    scl_q = 1'b0;
    hp();
  endtask : bit_io
  // eight bits msb first, then the ack slot
  task automatic byte_io(input bsid_byte_type tx, output bsid_byte_type rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io
  // stop condition
  task automatic stop();
    sda_q = 1'b0;
    hp();
    scl_q = 1'b1;
    hp();
    sda_q = 1'b1;
    hp();
  endtask : stop
  // read byte: addr, command, repeated start, data, nack
  task automatic rd(input logic [6:0] a, input bsid_byte_type c, output bsid_byte_type d, output logic [2:0] k);
    bsid_byte_type junk;
    start();
    byte_io({a, 1'b0}, junk, k[2]);
    byte_io(c, junk, k[1]);
    start();
    byte_io({a, 1'b1}, junk, k[0]);
    byte_io(8'hFF, d, junk[0]);
    stop();
  endtask : rd
  // write byte: addr, command, data
  task automatic wr(input logic [6:0] a, input bsid_byte_type c, input bsid_byte_type d, output logic [2:0] k);
    bsid_byte_type junk;
    start();
    byte_io({a, 1'b0}, junk, k[2]);
    byte_io(c, junk, k[1]);
    byte_io(d, junk, k[0]);
    stop();
  endtask : wr
endmodule : bsid_host_model

// ==== dv/bsid_regs_test.sv ====
`include "bsid_params.svh"
module bsid_regs_test import bsid_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam logic [3:0] MAKER = 4'h5; // arbitrary maker value
  localparam logic [2:0] REV = 3'h0; // first release
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic th = 1'b0; // thermal fault
  logic oc = 1'b0; // overcurrent
  logic bl = 1'b0; // backlight on
  logic [7:0] str_dis = 8'h00; // disabled strings
  logic scl;
  logic sda;
  logic dev_oe;
  logic dev_out; // device data drive value
  bsid_byte_type rd_data;
  logic [2:0] rd_acks;
  int err_count = 0;
  int compares = 0;
  // input patterns {thermal, overcurrent, backlight, strings}
  logic [10:0] vec [9] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h001, 11'h081, 11'h0FF, 11'h7FF, 11'h000};
  always #10 clk = ~clk;
  bsid_regs #(.MAKER_CODE(MAKER), .REVISION(REV)) dut (
    .SYS_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .SMB_SCL_IN(scl),
    .SMB_SDA_IN(sda),
    .SMB_SDA_OUT(dev_out),
    .SMB_SDA_OE_OUT(dev_oe),
    .THERMAL_FAULT_IN(th),
    .OVERCURRENT_IN(oc),
    .BACKLIGHT_ON_IN(bl),
    .STRING_DISABLED_IN(str_dis)
  );
  bsid_host_model host (.clk_in(clk), .dev_oe_in(dev_oe), .dev_out_in(dev_out), .scl_out(scl), .sda_out(sda));
  // ----------------------------------------
  // checks and helpers
  // ----------------------------------------
  task automatic check8(input bsid_byte_type got, input bsid_byte_type exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic check3(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t acks got=%h exp=%h", $time, got, exp);
    end
  endtask : check3
  // expected status byte from the pattern
  function automatic bsid_byte_type st_exp(input logic [10:0] v);
    int n;
    n = $countones(v[7:0]);
    return {2'b00, n > 1, n > 0, v[8], v[9], v[10], v[10] | v[9] | (n > 0)};
  endfunction : st_exp
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
  endtask : reset_dut
  task automatic drive(input logic [10:0] v);
    @(posedge clk);
    #2;
    {th, oc, bl, str_dis} = v;
  endtask : drive
  // read byte with all acks expected
  task automatic rd_chk(input bsid_byte_type c, input bsid_byte_type exp);
    host.rd(`BSID_SLAVE_ADDR, c, rd_data, rd_acks);
    check3(rd_acks, 3'h0);
    check8(rd_data, exp);
  endtask : rd_chk
  task automatic wr_chk(input bsid_byte_type c, input bsid_byte_type d);
    host.wr(`BSID_SLAVE_ADDR, c, d, rd_acks);
    check3(rd_acks, 3'h0);
  endtask : wr_chk
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    reset_dut();
    rd_chk(`BSID_REG_ID, {1'b1, MAKER, REV});
    wr_chk(`BSID_REG_ID, 8'h00);
    rd_chk(`BSID_REG_ID, {1'b1, MAKER, REV});
    wr_chk(`BSID_REG_STATUS, 8'hFF);
    // every field alone and combined, ending all clear
    foreach (vec[i]) begin
      drive(vec[i]);
      rd_chk(`BSID_REG_STATUS, st_exp(vec[i]));
    end
    rd_chk(`BSID_UNMAPPED_BYTE, 8'h00);
    // foreign address: no ack, line left to the pull-up
    host.rd(`BSID_SLAVE_ADDR ^ 7'h01, `BSID_REG_ID, rd_data, rd_acks);
    check3(rd_acks, 3'h7);
    check8(rd_data, 8'hFF);
    reset_dut();
    rd_chk(`BSID_REG_ID, {1'b1, MAKER, REV});
    final_report();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule : bsid_regs_test

// ==== hw/bsid_params.svh ====
`ifndef BSID_PARAMS_SVH
`define BSID_PARAMS_SVH
// ----------------------------------------
// register numbers on the serial bus
// ----------------------------------------
`define BSID_REG_STATUS 8'h02
`define BSID_REG_ID 8'h03
`define BSID_UNMAPPED_BYTE 8'h00
// ----------------------------------------
// status field positions
// ----------------------------------------
`define BSID_ST_FAULT 0
`define BSID_ST_THERMAL 1
`define BSID_ST_OVERCUR 2
`define BSID_ST_BACKLIGHT 3
`define BSID_ST_ANY_STR 4
`define BSID_ST_MULTI_STR 5
`define BSID_ST_RESERVED 2'h0
// ----------------------------------------
// identification fields and defaults
// ----------------------------------------
`define BSID_PANEL_LED 1'h1
`define BSID_MAKER_CODE 4'h9 // arbitrary value
`define BSID_REVISION 3'h0
// ----------------------------------------
// serial engine constants
// ----------------------------------------
`define BSID_SLAVE_ADDR 7'h2C
`define BSID_STRINGS 8
`define BSID_BITS_PER_BYTE 4'h8
`define BSID_FIRST_BIT 4'h1
`define BSID_CNT_ZERO 4'h0
`define BSID_CNT_ONE 4'h1
`endif

// ==== hw/bsid_pkg.sv ====
package bsid_pkg;
  // ----------------------------------------
  // shared types
  // ----------------------------------------
  typedef logic [7:0] bsid_byte_type; // one register byte
  // serial slave states
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK
  } bsid_state_type;
endpackage : bsid_pkg

// ==== hw/bsid_regs.sv ====
// Function
// - status bit0 is OR of faults
// - status bit1 shows thermal fault
// - status bit2 shows input overcurrent
// - status bit3 shows backlight on
// - bits 5:4 encode none, one, many strings
// - identification register ignores all writes
// - bits 6:3 hold maker code
// - bits 2:0 hold silicon revision
// - revision starts at zero, steps per release
// - bit 7 reads one for panel
// - host reads registers by serial byte read
// - status read only, reserved bits zero
// - string count reflects disabled current sources
`include "bsid_params.svh"
module bsid_regs import bsid_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = `BSID_SLAVE_ADDR,
  parameter logic [3:0] MAKER_CODE = `BSID_MAKER_CODE, // arbitrary value
  parameter logic [2:0] REVISION = `BSID_REVISION,
  parameter int STRINGS = `BSID_STRINGS
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SMB_SCL_IN,
  input wire logic SMB_SDA_IN,
  output logic SMB_SDA_OUT,
  output logic SMB_SDA_OE_OUT,
  input wire logic THERMAL_FAULT_IN,
  input wire logic OVERCURRENT_IN,
  input wire logic BACKLIGHT_ON_IN,
  input wire logic [STRINGS-1:0] STRING_DISABLED_IN
);
  // assertion clock and reset for the whole module
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // ----------------------------------------
  // status encoder
  // ----------------------------------------
  bsid_stat_if stat_if ();
  bsid_status_enc #(.STRINGS(STRINGS)) u_enc (
    .thermal_in(THERMAL_FAULT_IN),
    .overcurrent_in(OVERCURRENT_IN),
    .backlight_on_in(BACKLIGHT_ON_IN),
    .string_disabled_in(STRING_DISABLED_IN),
    .stat(stat_if.enc)
  );

  bsid_byte_type id_byte; // fixed identity, no reset involved
  assign id_byte = {`BSID_PANEL_LED, MAKER_CODE, REVISION};

  // register select by number
  function automatic bsid_byte_type sel_reg(input bsid_byte_type num, input bsid_byte_type st,
                                            input bsid_byte_type id);
    if (num == `BSID_REG_STATUS) begin
      sel_reg = st;
    end else if (num == `BSID_REG_ID) begin
      sel_reg = id;
    end else begin
      sel_reg = `BSID_UNMAPPED_BYTE;
    end
  endfunction : sel_reg

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] scl_sync_q; // three stage clock pin chain
  logic [2:0] sda_sync_q; // three stage data pin chain
  logic scl_f_q; // accepted clock level
  logic sda_f_q; // accepted data level
  logic scl_prev_q; // previous accepted clock
  logic sda_prev_q; // previous accepted data

  // shift chains, idle high
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], SMB_SCL_IN};
      sda_sync_q <= {sda_sync_q[1:0], SMB_SDA_IN};
    end
  end

  // level accepted once stages two and three agree
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      scl_f_q <= 1'h1;
      sda_f_q <= 1'h1;
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_f_q <= sda_sync_q[2];
      end
      scl_prev_q <= scl_f_q;
      sda_prev_q <= sda_f_q;
    end
  end

  logic scl_rise; // clock rose
  logic scl_fall; // clock fell
  logic start_evt; // data fell with clock high
  logic stop_evt; // data rose with clock high
  assign scl_rise = scl_f_q & ~scl_prev_q;
  assign scl_fall = ~scl_f_q & scl_prev_q;
  assign start_evt = ~sda_f_q & sda_prev_q & scl_f_q & scl_prev_q;
  assign stop_evt = sda_f_q & ~sda_prev_q & scl_f_q & scl_prev_q;

  // ----------------------------------------
  // serial slave engine
  // ----------------------------------------
  bsid_state_type state_q; // current phase
  bsid_state_type nxt_q; // phase after the ack slot
  logic [3:0] cnt_q; // bit counter
  bsid_byte_type shreg_q; // received byte
  bsid_byte_type ptr_q; // selected register number
  bsid_byte_type tx_q; // outgoing byte snapshot
  logic sda_oe_q; // pull data low
  logic tx_load; // snapshot moment
  logic byte_done; // eight bits received or sent

  assign byte_done = scl_fall && (cnt_q == `BSID_BITS_PER_BYTE);
  assign tx_load = (state_q == ST_ACK) && scl_fall && (nxt_q == ST_RDATA);

  bsid_byte_type sel_byte; // byte of the selected register, this cycle
  assign sel_byte = sel_reg(ptr_q, stat_if.status_byte, id_byte);

  // protocol phases, bit count, pin drive
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      nxt_q <= ST_IDLE;
      cnt_q <= `BSID_CNT_ZERO;
      shreg_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'h0;
    end else if (start_evt) begin
      // start or repeated start: expect an address
      state_q <= ST_ADDR;
      cnt_q <= `BSID_CNT_ZERO;
      sda_oe_q <= 1'h0;
    end else if (stop_evt) begin
      state_q <= ST_IDLE;
      sda_oe_q <= 1'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sda_oe_q <= 1'h0;
        end
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (scl_rise) begin
            shreg_q <= {shreg_q[6:0], sda_f_q};
            cnt_q <= cnt_q + `BSID_CNT_ONE;
          end else if (byte_done) begin
            if (state_q == ST_ADDR) begin
              // own address: ack, then read or take command
              if (shreg_q[7:1] == SLAVE_ADDR) begin
                sda_oe_q <= 1'h1;
                state_q <= ST_ACK;
                nxt_q <= shreg_q[0] ? ST_RDATA : ST_CMD;
              end else begin
                state_q <= ST_IDLE;
              end
            end else begin
              // command selects register; data bytes are dropped
              if (state_q == ST_CMD) begin
                ptr_q <= shreg_q;
              end
              sda_oe_q <= 1'h1;
              state_q <= ST_ACK;
              nxt_q <= ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            state_q <= nxt_q;
            if (nxt_q == ST_RDATA) begin
              // first data bit goes out now
              sda_oe_q <= ~sel_byte[7];
              cnt_q <= `BSID_FIRST_BIT;
            end else begin
              sda_oe_q <= 1'h0;
              cnt_q <= `BSID_CNT_ZERO;
            end
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe_q <= 1'h0;
            state_q <= ST_MACK;
          end else if (scl_fall) begin
            sda_oe_q <= ~tx_q[6];
            cnt_q <= cnt_q + `BSID_CNT_ONE;
          end
        end
        ST_MACK: begin
          // single byte read: done after the host's ack slot
          if (scl_fall) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // outgoing byte snapshot
  // ----------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_q <= 8'h00;
    end else if (tx_load) begin
      tx_q <= sel_byte;
    end else if ((state_q == ST_RDATA) && scl_fall && !byte_done) begin
      tx_q <= {tx_q[6:0], 1'h0};
    end
  end

  assign SMB_SDA_OUT = 1'h0; // open drain: only ever pulls low
  assign SMB_SDA_OE_OUT = sda_oe_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  bsid_byte_type st; // shorthand
  assign st = stat_if.status_byte;

  sequence s_load;
    tx_load;
  endsequence
  sequence s_first_bit;
    state_q == ST_RDATA && sda_oe_q == ~tx_q[7];
  endsequence

  a_fault_summary: assert property (st[`BSID_ST_FAULT] == (THERMAL_FAULT_IN | OVERCURRENT_IN
    | (|STRING_DISABLED_IN))) else $error("fault summary wrong");
  a_thermal_bit: assert property (st[`BSID_ST_THERMAL] == THERMAL_FAULT_IN)
    else $error("thermal bit wrong");
  a_overcur_bit: assert property (st[`BSID_ST_OVERCUR] == OVERCURRENT_IN)
    else $error("overcurrent bit wrong");
  a_backlight_bit: assert property (st[`BSID_ST_BACKLIGHT] == BACKLIGHT_ON_IN)
    else $error("backlight bit wrong");
  a_string_count: assert property (st[5:4] != 2'h2 && (st[`BSID_ST_ANY_STR] == (|STRING_DISABLED_IN))
    && (st[`BSID_ST_MULTI_STR] == ($countones(STRING_DISABLED_IN) > 1))) else $error("string count encoding wrong");
  a_id_fields: assert property (id_byte[7] == `BSID_PANEL_LED && id_byte[6:3] == MAKER_CODE
    && id_byte[2:0] == REVISION) else $error("identification fields wrong");
  a_id_fixed: assert property (##1 $stable(id_byte)) else $error("identification changed");
  a_reserved_zero: assert property (st[7:6] == 2'h0) else $error("reserved status bits set");
  a_read_snapshot: assert property (s_load |=> tx_q == $past(sel_byte) ##0 s_first_bit)
    else $error("read byte not sampled coherently");
  a_stop_release: assert property (stop_evt |=> state_q == ST_IDLE && !sda_oe_q)
    else $error("stop did not release bus");
endmodule : bsid_regs

// ==== hw/bsid_stat_if.sv ====
interface bsid_stat_if;
  import bsid_pkg::*;
  bsid_byte_type status_byte; // live status byte
  modport enc (output status_byte);
  modport regs (input status_byte);
endinterface : bsid_stat_if

// ==== hw/bsid_status_enc.sv ====
`include "bsid_params.svh"
module bsid_status_enc import bsid_pkg::*; #(
  parameter int STRINGS = `BSID_STRINGS
) (
  input wire logic thermal_in,
  input wire logic overcurrent_in,
  input wire logic backlight_on_in,
  input wire logic [STRINGS-1:0] string_disabled_in,
  bsid_stat_if.enc stat
);
  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (STRINGS < 2) begin : g_bad_strings
    $error("bsid_status_enc needs at least two strings");
  end

  // more than one bit set: clearing the lowest leaves something
  function automatic logic multi_set(input logic [STRINGS-1:0] v);
    multi_set = |(v & (v - STRINGS'(1)));
  endfunction : multi_set

  logic any_string_fault; // one or more strings disabled
  logic multi_string_fault; // two or more strings disabled
  logic thermal_shutdown_flag; // thermal fault live
  logic input_overcurrent_flag; // overcurrent live
  logic backlight_on_status; // backlight on

  // ----------------------------------------
  // live encode, no latching
  // ----------------------------------------
  always_comb begin
    thermal_shutdown_flag = thermal_in;
    input_overcurrent_flag = overcurrent_in;
    backlight_on_status = backlight_on_in;
    any_string_fault = |string_disabled_in;
    multi_string_fault = multi_set(string_disabled_in);
    stat.status_byte = {`BSID_ST_RESERVED, multi_string_fault, any_string_fault,
                        backlight_on_status, input_overcurrent_flag, thermal_shutdown_flag,
                        thermal_shutdown_flag | input_overcurrent_flag | any_string_fault};
  end
endmodule : bsid_status_enc
